// ### hw/fdps_pid.sv
// PID arithmetic core, one update per loop period strobe
`timescale 1ns/1ps
module fdps_pid (
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	// Control
	input  wire logic               clear_in,
	input  wire logic               update_in,
	input  wire logic signed [16:0] error_in,
	// Gains and period
	input  wire logic        [15:0] kp_in,
	input  wire logic        [15:0] ki_in,
	input  wire logic        [15:0] kd_in,
	input  wire logic        [15:0] period_in,
	// Result
	output logic signed      [31:0] result_out
);

	logic signed [51:0] integ_ff;
	logic signed [51:0] nxt_integ;
	logic signed [16:0] prev_err_ff;
	wire  signed [16:0] per_w;
	wire  signed [33:0] prop_w;
	wire  signed [50:0] istep_w;
	wire  signed [17:0] diff_w;
	wire  signed [34:0] dnum_w;
	wire  signed [34:0] deriv_w;
	wire  signed [51:0] sum_w;

	// Zero period would divide by zero; treat it as one tick
	assign per_w   = (period_in == 16'h0000) ? 17'sd1 : $signed({1'b0, period_in});
	assign prop_w  = $signed({1'b0, kp_in}) * error_in;
	assign istep_w = $signed({1'b0, ki_in}) * error_in * per_w;
	assign diff_w  = 18'(error_in) - 18'(prev_err_ff);
	assign dnum_w  = $signed({1'b0, kd_in}) * diff_w;
	assign deriv_w = dnum_w / 35'(per_w);
	assign nxt_integ = integ_ff + 52'(istep_w);
	assign sum_w   = 52'(prop_w) + nxt_integ + 52'(deriv_w);

	always_ff @(posedge mclk_in) begin
		if (rst_in || clear_in) begin
			integ_ff    <= '0;
			prev_err_ff <= '0;
			result_out  <= '0;
		end else if (update_in) begin
			integ_ff    <= nxt_integ;
			prev_err_ff <= error_in;
			result_out  <= sum_w[fdps_pkg::PID_SHIFT +: 32];
		end
	end

endmodule : fdps_pid

// ### hw/fdps_pkg.sv
// Constants, register map and types for the fan drive start and PID supervisor
package fdps_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned TICK_TIME_US  = 1000;
	localparam int unsigned TICK_CYCLES   = TICK_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned ALIGN_TIME_MS = 1000;
	localparam int unsigned DRAG_TIME_MS  = 8000;
	localparam logic [15:0] ALIGN_TICKS   = 16'(ALIGN_TIME_MS * 1000 / TICK_TIME_US);
	localparam logic [15:0] DRAG_TICKS    = 16'(DRAG_TIME_MS * 1000 / TICK_TIME_US);

	// Register offsets, input register space
	localparam logic [7:0] IR_SPEED_REF  = 8'h02;
	localparam logic [7:0] IR_MEAS_SPEED = 8'h03;
	localparam logic [7:0] IR_PEAK_CUR   = 8'h0C;
	localparam logic [7:0] IR_OUT_VOLT   = 8'h0D;
	localparam logic [7:0] IR_IN_POWER   = 8'h20;

	// Register offsets, holding register space
	localparam logic [7:0] HR_CUR_LIMIT   = 8'h07;
	localparam logic [7:0] HR_FB_SIGN     = 8'h1F;
	localparam logic [7:0] HR_POWER_LIMIT = 8'h24;
	localparam logic [7:0] HR_DOUT_FUNC   = 8'h2E;
	localparam logic [7:0] HR_PID_REF     = 8'h32;
	localparam logic [7:0] HR_ALARM_THR   = 8'h37;

	// Reset values
	localparam logic [15:0] CUR_LIMIT_RST   = 16'h2260;
	localparam logic [15:0] FB_SIGN_RST     = 16'h0000;
	localparam logic [15:0] POWER_LIMIT_RST = 16'h0834;
	localparam logic [15:0] DOUT_FUNC_RST   = 16'h0000;
	localparam logic [15:0] PID_REF_RST     = 16'h0000;
	localparam logic [15:0] ALARM_THR_RST   = 16'h0000;

	// Field values and limits
	localparam logic [7:0]  INPUT_TYPE_SLAVE     = 8'h03;
	localparam logic [7:0]  INPUT_TYPE_FIXED_PID = 8'h0C;
	localparam logic [15:0] DOUT_SPEED_PULSE_OUTPUT           = 16'h0000;
	localparam logic [15:0] DOUT_ALARM           = 16'h0002;
	localparam logic [15:0] BACK_BRAKE_RPM       = 16'h00C8;
	localparam logic [15:0] PID_VOLT_MAX         = 16'h0064;
	localparam int unsigned PID_SHIFT            = 8;
	localparam int unsigned SPEED_PULSE_OUTPUT_ACC_W          = 24;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALIGN,
		ST_DRAG,
		ST_CLOSED,
		ST_TRIP
	} fdps_state_t;

endpackage : fdps_pkg

// ### hw/fdps_supervisor.sv
// Fan drive supervisor: start sequence, PID, limits, digital output, registers
// Summary of operation
// - Input type 12 takes reference from register
// - Error is reference minus analog measurement
// - Sign register one inverts the error
// - PID sum updated once per loop period
// - Analog input is process variable, 0-10V
// - Slave with type 3 follows master speed
// - Function 0 drives speed pulse output
// - Function 2 makes output a threshold alarm
// - Alarm asserted while speed exceeds threshold
// - Start begins with one second alignment
// - Slow reverse braked, fast reverse trips
// - Eight second open-loop drag to minimum
// - Closed-loop ramp, deceleration below acceleration
// - Speed reference readback: minimum, then set
// - Readback reports measured motor speed
// - Motor power held below power limit
// - Readback reports instantaneous input power
// - Peak current capped at current limit
// - Readback reports peak motor current
// - Readback reports motor output voltage
`timescale 1ns/1ps
module fdps_supervisor #(
	parameter int unsigned TICK_CYCLES = fdps_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	// Register port from the serial protocol engine
	input  wire logic               reg_input_space_in,
	input  wire logic        [7:0]  reg_addr_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	input  wire logic        [15:0] reg_wdata_in,
	output logic             [15:0] reg_rdata_out,
	output logic                    reg_ack_out,
	output logic                    reg_err_out,
	// Operating configuration
	input  wire logic               run_cmd_in,
	input  wire logic        [7:0]  input_type_in,
	input  wire logic        [15:0] min_speed_in,
	input  wire logic        [15:0] max_speed_in,
	input  wire logic        [15:0] accel_in,
	input  wire logic        [15:0] decel_in,
	input  wire logic        [15:0] kp_in,
	input  wire logic        [15:0] ki_in,
	input  wire logic        [15:0] kd_in,
	input  wire logic        [15:0] loop_update_period_in,
	// Speed sources
	input  wire logic        [15:0] analog_in,
	input  wire logic        [15:0] setpoint_in,
	input  wire logic        [15:0] master_speed_in,
	// Motor measurements
	input  wire logic signed [15:0] measured_speed_in,
	input  wire logic        [15:0] current_in,
	input  wire logic        [15:0] voltage_in,
	input  wire logic        [15:0] power_in,
	// Drive outputs
	output logic             [15:0] speed_cmd_out,
	output logic             [15:0] current_cap_out,
	output logic                    brake_out,
	output logic                    trip_out,
	output logic                    power_limit_active_out,
	output logic                    speed_pulse_output_out,
	output logic                    alarm_out
);

	fdps_pkg::fdps_state_t state_ff;
	fdps_pkg::fdps_state_t nxt_state;

	// Registers
	logic [15:0] cur_limit_ff;
	logic [15:0] fb_sign_ff;
	logic [15:0] power_limit_ff;
	logic [15:0] dout_func_ff;
	logic [15:0] pid_ref_ff;
	logic [15:0] alarm_thr_ff;
	logic [15:0] peak_cur_ff;
	logic [15:0] speed_ref_ff;
	// Sequencing
	logic        run_meta_ff;
	logic        run_sync_ff;
	logic [15:0] tick_cnt_ff;
	logic [15:0] phase_cnt_ff;
	logic [15:0] drag_frac_ff;
	logic [15:0] drag_speed_ff;
	logic [15:0] ramp_ff;
	logic [15:0] loop_cnt_ff;
	logic [fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W-1:0] speed_pulse_output_acc_ff;

	wire               tick_w;
	wire               hr_sel_w;
	wire               ir_sel_w;
	wire               mapped_w;
	wire        [15:0] hr_rdata_w;
	wire        [15:0] ir_rdata_w;
	wire        [15:0] meas_v_w;
	wire        [15:0] ref_v_w;
	wire signed [16:0] error_w;
	wire               fixed_pid_w;
	wire               pid_tick_w;
	wire signed [31:0] pid_out_w;
	wire        [15:0] pid_speed_w;
	wire        [15:0] raw_target_w;
	wire        [15:0] target_w;
	wire        [15:0] eff_decel_w;
	wire        [15:0] up_step_w;
	wire        [15:0] down_step_w;
	wire               power_over_w;
	wire               reverse_w;
	wire        [15:0] reverse_mag_w;
	wire               slow_reverse_w;
	wire               fast_reverse_w;
	wire               over_thr_w;
	wire        [15:0] fwd_speed_w;
	wire        [fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W:0] speed_pulse_output_sum_w;
	wire        [15:0] nxt_ramp;
	wire        [16:0] drag_sum_w;

	assign tick_w = (tick_cnt_ff == 16'(TICK_CYCLES - 1));

	// Register decode
	assign hr_sel_w = !reg_input_space_in;
	assign ir_sel_w = reg_input_space_in;
	assign hr_rdata_w =
		(reg_addr_in == fdps_pkg::HR_CUR_LIMIT)   ? cur_limit_ff   :
		(reg_addr_in == fdps_pkg::HR_FB_SIGN)     ? fb_sign_ff     :
		(reg_addr_in == fdps_pkg::HR_POWER_LIMIT) ? power_limit_ff :
		(reg_addr_in == fdps_pkg::HR_DOUT_FUNC)   ? dout_func_ff   :
		(reg_addr_in == fdps_pkg::HR_PID_REF)     ? pid_ref_ff     :
		(reg_addr_in == fdps_pkg::HR_ALARM_THR)   ? alarm_thr_ff   : 16'h0000;
	assign ir_rdata_w =
		(reg_addr_in == fdps_pkg::IR_SPEED_REF)  ? speed_ref_ff                :
		(reg_addr_in == fdps_pkg::IR_MEAS_SPEED) ? measured_speed_in           :
		(reg_addr_in == fdps_pkg::IR_PEAK_CUR)   ? peak_cur_ff                 :
		(reg_addr_in == fdps_pkg::IR_OUT_VOLT)   ? voltage_in                  :
		(reg_addr_in == fdps_pkg::IR_IN_POWER)   ? power_in                    :
		16'h0000;
	assign mapped_w = hr_sel_w ?
		(reg_addr_in == fdps_pkg::HR_CUR_LIMIT || reg_addr_in == fdps_pkg::HR_FB_SIGN ||
		 reg_addr_in == fdps_pkg::HR_POWER_LIMIT || reg_addr_in == fdps_pkg::HR_DOUT_FUNC ||
		 reg_addr_in == fdps_pkg::HR_PID_REF || reg_addr_in == fdps_pkg::HR_ALARM_THR) :
		(reg_addr_in == fdps_pkg::IR_SPEED_REF || reg_addr_in == fdps_pkg::IR_MEAS_SPEED ||
		 reg_addr_in == fdps_pkg::IR_PEAK_CUR || reg_addr_in == fdps_pkg::IR_OUT_VOLT ||
		 reg_addr_in == fdps_pkg::IR_IN_POWER);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cur_limit_ff   <= fdps_pkg::CUR_LIMIT_RST;
			fb_sign_ff     <= fdps_pkg::FB_SIGN_RST;
			power_limit_ff <= fdps_pkg::POWER_LIMIT_RST;
			dout_func_ff   <= fdps_pkg::DOUT_FUNC_RST;
			pid_ref_ff     <= fdps_pkg::PID_REF_RST;
			alarm_thr_ff   <= fdps_pkg::ALARM_THR_RST;
		end else if (reg_wr_in && hr_sel_w) begin
			if (reg_addr_in == fdps_pkg::HR_CUR_LIMIT) begin
				cur_limit_ff <= reg_wdata_in;
			end else if (reg_addr_in == fdps_pkg::HR_FB_SIGN) begin
				fb_sign_ff <= reg_wdata_in;
			end else if (reg_addr_in == fdps_pkg::HR_POWER_LIMIT) begin
				power_limit_ff <= reg_wdata_in;
			end else if (reg_addr_in == fdps_pkg::HR_DOUT_FUNC) begin
				dout_func_ff <= reg_wdata_in;
			end else if (reg_addr_in == fdps_pkg::HR_PID_REF) begin
				pid_ref_ff <= reg_wdata_in;
			end else if (reg_addr_in == fdps_pkg::HR_ALARM_THR) begin
				alarm_thr_ff <= reg_wdata_in;
			end
		end
	end

	// Input space is read-only; writing it is an error
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
			reg_ack_out   <= 1'b0;
			reg_err_out   <= 1'b0;
		end else begin
			reg_ack_out   <= reg_rd_in || reg_wr_in;
			reg_err_out   <= (reg_rd_in || reg_wr_in) && (!mapped_w || (reg_wr_in && ir_sel_w));
			if (reg_rd_in) begin
				reg_rdata_out <= hr_sel_w ? hr_rdata_w : ir_rdata_w;
			end
		end
	end

	// PID error in 0.1 V units, both sides held to 0..100
	assign meas_v_w = (analog_in > fdps_pkg::PID_VOLT_MAX) ? fdps_pkg::PID_VOLT_MAX : analog_in;
	assign ref_v_w  = (pid_ref_ff > fdps_pkg::PID_VOLT_MAX) ? fdps_pkg::PID_VOLT_MAX : pid_ref_ff;
	assign error_w  = fb_sign_ff[0] ? (17'(meas_v_w) - 17'(ref_v_w))
	                                : (17'(ref_v_w) - 17'(meas_v_w));
	assign fixed_pid_w = (input_type_in == fdps_pkg::INPUT_TYPE_FIXED_PID);
	assign pid_tick_w  = tick_w && (loop_cnt_ff >= loop_update_period_in) && fixed_pid_w &&
	                     (state_ff == fdps_pkg::ST_CLOSED);

	fdps_pid u_pid (
		.mclk_in    (mclk_in),
		.rst_in     (rst_in),
		.clear_in   (state_ff != fdps_pkg::ST_CLOSED),
		.update_in  (pid_tick_w),
		.error_in   (error_w),
		.kp_in      (kp_in),
		.ki_in      (ki_in),
		.kd_in      (kd_in),
		.period_in  (loop_update_period_in),
		.result_out (pid_out_w)
	);

	assign pid_speed_w = pid_out_w[31] ? 16'h0000 :
	                     (|pid_out_w[30:16]) ? 16'hFFFF : pid_out_w[15:0];
	assign raw_target_w = fixed_pid_w ? pid_speed_w :
	                      (input_type_in == fdps_pkg::INPUT_TYPE_SLAVE) ? master_speed_in :
	                      setpoint_in;
	assign target_w = (raw_target_w < min_speed_in) ? min_speed_in :
	                  (raw_target_w > max_speed_in) ? max_speed_in : raw_target_w;

	// Deceleration kept strictly below a nonzero acceleration to avoid overvoltage
	assign eff_decel_w  = (decel_in < accel_in) ? decel_in :
	                      ((accel_in == 16'h0000) ? 16'h0000 : accel_in - 16'h0001);
	assign power_over_w = (power_in >= power_limit_ff);
	assign up_step_w    = ((target_w - ramp_ff) < accel_in) ? (target_w - ramp_ff) : accel_in;
	assign down_step_w  = power_over_w ? eff_decel_w :
	                      (((ramp_ff - target_w) < eff_decel_w) ? (ramp_ff - target_w) : eff_decel_w);
	assign nxt_ramp =
		(power_over_w && ramp_ff > min_speed_in) ?
			(((ramp_ff - min_speed_in) < down_step_w) ? min_speed_in : ramp_ff - down_step_w) :
		(ramp_ff < target_w) ? ramp_ff + up_step_w :
		(ramp_ff > target_w) ? ramp_ff - down_step_w : ramp_ff;

	// Reverse rotation at start
	assign reverse_w      = measured_speed_in[15];
	assign reverse_mag_w  = 16'(-measured_speed_in);
	assign slow_reverse_w = reverse_w && (reverse_mag_w < fdps_pkg::BACK_BRAKE_RPM);
	assign fast_reverse_w = reverse_w && !slow_reverse_w;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fdps_pkg::ST_IDLE: begin
				if (run_sync_ff) begin
					nxt_state = fdps_pkg::ST_ALIGN;
				end
			end
			fdps_pkg::ST_ALIGN: begin
				if (!run_sync_ff) begin
					nxt_state = fdps_pkg::ST_IDLE;
				end else if (fast_reverse_w) begin
					nxt_state = fdps_pkg::ST_TRIP;
				end else if (tick_w && phase_cnt_ff == fdps_pkg::ALIGN_TICKS - 16'h0001) begin
					nxt_state = fdps_pkg::ST_DRAG;
				end
			end
			fdps_pkg::ST_DRAG: begin
				if (!run_sync_ff) begin
					nxt_state = fdps_pkg::ST_IDLE;
				end else if (tick_w && phase_cnt_ff == fdps_pkg::DRAG_TICKS - 16'h0001) begin
					nxt_state = fdps_pkg::ST_CLOSED;
				end
			end
			fdps_pkg::ST_CLOSED: begin
				if (!run_sync_ff) begin
					nxt_state = fdps_pkg::ST_IDLE;
				end
			end
			default: begin
				if (!run_sync_ff) begin
					nxt_state = fdps_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			run_meta_ff <= 1'b0;
			run_sync_ff <= 1'b0;
			state_ff    <= fdps_pkg::ST_IDLE;
			tick_cnt_ff <= 16'h0000;
		end else begin
			run_meta_ff <= run_cmd_in;
			run_sync_ff <= run_meta_ff;
			state_ff    <= nxt_state;
			tick_cnt_ff <= tick_w ? 16'h0000 : tick_cnt_ff + 16'h0001;
		end
	end

	// Phase timer restarts on every state change
	assign drag_sum_w = 17'(drag_frac_ff) + 17'(min_speed_in);
	always_ff @(posedge mclk_in) begin
		if (rst_in || nxt_state != state_ff) begin
			phase_cnt_ff  <= 16'h0000;
			drag_frac_ff  <= 16'h0000;
			drag_speed_ff <= 16'h0000;
			loop_cnt_ff   <= 16'h0001;
		end else if (tick_w) begin
			phase_cnt_ff <= phase_cnt_ff + 16'h0001;
			loop_cnt_ff  <= pid_tick_w ? 16'h0001 : loop_cnt_ff + 16'h0001;
			if (state_ff == fdps_pkg::ST_DRAG) begin
				// Linear rise to minimum over the drag time
				if (drag_sum_w >= 17'(fdps_pkg::DRAG_TICKS)) begin
					drag_frac_ff  <= 16'(drag_sum_w - 17'(fdps_pkg::DRAG_TICKS));
					drag_speed_ff <= drag_speed_ff + 16'h0001;
				end else begin
					drag_frac_ff <= drag_sum_w[15:0];
				end
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ramp_ff       <= 16'h0000;
			speed_cmd_out <= 16'h0000;
			speed_ref_ff  <= 16'h0000;
		end else begin
			if (state_ff != fdps_pkg::ST_CLOSED) begin
				ramp_ff <= min_speed_in;
			end else if (tick_w) begin
				ramp_ff <= nxt_ramp;
			end
			case (state_ff)
				fdps_pkg::ST_DRAG:   speed_cmd_out <= drag_speed_ff;
				fdps_pkg::ST_CLOSED: speed_cmd_out <= ramp_ff;
				default:             speed_cmd_out <= 16'h0000;
			endcase
			speed_ref_ff <= (state_ff == fdps_pkg::ST_CLOSED) ? target_w : min_speed_in;
		end
	end

	// Peak current since the last start
	always_ff @(posedge mclk_in) begin
		if (rst_in || (state_ff == fdps_pkg::ST_IDLE && nxt_state == fdps_pkg::ST_ALIGN)) begin
			peak_cur_ff <= 16'h0000;
		end else if (state_ff != fdps_pkg::ST_IDLE && current_in > peak_cur_ff) begin
			peak_cur_ff <= current_in;
		end
	end

	// Digital output and protection flags
	assign fwd_speed_w = reverse_w ? 16'h0000 : measured_speed_in;
	assign over_thr_w  = (fwd_speed_w > alarm_thr_ff);
	assign speed_pulse_output_sum_w = (fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W + 1)'(speed_pulse_output_acc_ff) +
	                     (fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W + 1)'(fwd_speed_w);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			speed_pulse_output_acc_ff           <= '0;
			speed_pulse_output_out <= 1'b0;
			alarm_out              <= 1'b0;
			brake_out              <= 1'b0;
			trip_out               <= 1'b0;
			power_limit_active_out <= 1'b0;
			current_cap_out        <= fdps_pkg::CUR_LIMIT_RST;
		end else begin
			speed_pulse_output_acc_ff <= speed_pulse_output_sum_w[fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W-1:0];
			if (dout_func_ff == fdps_pkg::DOUT_SPEED_PULSE_OUTPUT) begin
				// Pulse rate follows measured speed for the slave to track
				speed_pulse_output_out <= speed_pulse_output_out ^
				                          speed_pulse_output_sum_w[fdps_pkg::SPEED_PULSE_OUTPUT_ACC_W];
			end else if (dout_func_ff == fdps_pkg::DOUT_ALARM) begin
				speed_pulse_output_out <= over_thr_w;
			end else begin
				speed_pulse_output_out <= 1'b0;
			end
			alarm_out              <= (dout_func_ff == fdps_pkg::DOUT_ALARM) && over_thr_w;
			brake_out              <= (state_ff == fdps_pkg::ST_ALIGN) && slow_reverse_w;
			trip_out               <= (nxt_state == fdps_pkg::ST_TRIP);
			power_limit_active_out <= (state_ff == fdps_pkg::ST_CLOSED) && power_over_w;
			current_cap_out        <= cur_limit_ff;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_start_align: assert property (state_ff == fdps_pkg::ST_IDLE && run_sync_ff
		|=> state_ff == fdps_pkg::ST_ALIGN) else $error("start did not enter alignment");
	a_drag_entry: assert property ($rose(state_ff == fdps_pkg::ST_DRAG)
		|-> $past(state_ff) == fdps_pkg::ST_ALIGN && $past(phase_cnt_ff) == fdps_pkg::ALIGN_TICKS - 16'h0001)
		else $error("drag entered without full alignment");
	a_closed_entry: assert property ($rose(state_ff == fdps_pkg::ST_CLOSED)
		|-> $past(phase_cnt_ff) == fdps_pkg::DRAG_TICKS - 16'h0001)
		else $error("closed loop entered before drag time");
	a_fast_reverse: assert property (state_ff == fdps_pkg::ST_ALIGN && run_sync_ff && fast_reverse_w
		|=> state_ff == fdps_pkg::ST_TRIP ##0 trip_out) else $error("fast reverse not tripped");
	a_slow_brake: assert property (state_ff == fdps_pkg::ST_ALIGN && slow_reverse_w
		|=> brake_out) else $error("slow reverse not braked");
	a_ref_readback: assert property (state_ff inside {fdps_pkg::ST_ALIGN, fdps_pkg::ST_DRAG}
		&& $stable(min_speed_in) |=> speed_ref_ff == $past(min_speed_in))
		else $error("speed reference not minimum at start");
	a_alarm_output: assert property (dout_func_ff == fdps_pkg::DOUT_ALARM ##1
		dout_func_ff == fdps_pkg::DOUT_ALARM |-> speed_pulse_output_out == $past(over_thr_w)
		&& alarm_out == speed_pulse_output_out) else $error("threshold alarm output wrong");
	a_target_clamp: assert property (fixed_pid_w && min_speed_in <= max_speed_in
		|-> target_w >= min_speed_in && target_w <= max_speed_in)
		else $error("PID speed outside limits");
	a_decel_below: assert property (state_ff == fdps_pkg::ST_CLOSED && tick_w && ramp_ff > nxt_ramp
		&& accel_in != 16'h0000 |-> (ramp_ff - nxt_ramp) < accel_in)
		else $error("deceleration step not below acceleration");
	a_power_hold: assert property (state_ff == fdps_pkg::ST_CLOSED && tick_w && power_over_w
		&& nxt_state == fdps_pkg::ST_CLOSED |=> ramp_ff <= $past(ramp_ff))
		else $error("speed raised above power limit");
	a_peak_track: assert property (state_ff != fdps_pkg::ST_IDLE && nxt_state != fdps_pkg::ST_IDLE
		|=> peak_cur_ff >= $past(current_in)) else $error("peak current missed");
	a_error_sign: assert property (fixed_pid_w && $changed(fb_sign_ff[0]) && $stable(meas_v_w)
		&& $stable(ref_v_w) && meas_v_w != ref_v_w |-> error_w == -$past(error_w))
		else $error("feedback sign did not invert error");

	c_reach_closed: cover property (state_ff == fdps_pkg::ST_DRAG ##1 state_ff == fdps_pkg::ST_CLOSED);
	c_trip:         cover property (state_ff == fdps_pkg::ST_ALIGN ##1 state_ff == fdps_pkg::ST_TRIP);
	c_alarm_rise:   cover property ($rose(alarm_out));
	c_pid_update:   cover property (pid_tick_w);

endmodule : fdps_supervisor

// ### verification/fdps_motor_model.sv
// Motor and transducer stand-in on the far side of the supervisor
`timescale 1ns/1ps
module fdps_motor_model (
	// Drive command and injected reverse spin
	input  wire logic        [15:0] speed_cmd_in,
	input  wire logic        [15:0] reverse_rpm_in,
	// Measurements back to the supervisor
	output logic signed      [15:0] measured_speed_out,
	output logic             [15:0] current_out,
	output logic             [15:0] voltage_out,
	output logic             [15:0] power_out
);
	// Ideal motor: speed follows command unless spun backwards
	assign measured_speed_out = (reverse_rpm_in != 16'h0000) ? -$signed(reverse_rpm_in)
		: $signed(speed_cmd_in);
	assign current_out        = speed_cmd_in << 1;
	assign voltage_out        = speed_cmd_in >> 2;
	assign power_out          = speed_cmd_in;
endmodule : fdps_motor_model

// ### verification/fdps_supervisor_tb.sv
// Self-checking bench for the fan drive supervisor
`timescale 1ns/1ps
module fdps_supervisor_tb;
	typedef struct {logic s; logic [7:0] a; logic w; logic [15:0] d, e; logic r;} fdps_row_t;
	logic               mclk_in = 0;
	logic               rst_in = 1;
	logic               sp = 0, wr = 0, rd = 0, run = 0, ack, err, brk, trip, plim, pulse, alarm;
	logic        [7:0]  a = 0, itype = 0;
	logic        [15:0] d = 0, mn = 16'h0190, mx = 16'h07D0, kp = 0, ana = 16'h001E;
	logic        [15:0] rev = 0, mspd = 16'h05DC, tgt = 16'h03E8, dcl = 16'h0005;
	logic        [15:0] rdata, cmd, cap, cur, volt, pwr;
	logic signed [15:0] meas;
	fdps_row_t          rows [8];
	int                 n_errors = 0, compares = 0, cyc = 0, k;
	always #50 mclk_in = ~mclk_in;
	fdps_motor_model u_model (.speed_cmd_in(cmd), .reverse_rpm_in(rev),
		.measured_speed_out(meas), .current_out(cur), .voltage_out(volt), .power_out(pwr));
	fdps_supervisor #(.TICK_CYCLES(4)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in),
		.reg_input_space_in(sp), .reg_addr_in(a), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(d), .reg_rdata_out(rdata), .reg_ack_out(ack), .reg_err_out(err),
		.run_cmd_in(run), .input_type_in(itype), .min_speed_in(mn), .max_speed_in(mx),
		.accel_in(16'h000A), .decel_in(dcl), .kp_in(kp), .ki_in(16'h0000),
		.kd_in(16'h0000), .loop_update_period_in(16'h0001), .analog_in(ana),
		.setpoint_in(tgt), .master_speed_in(mspd), .measured_speed_in(meas),
		.current_in(cur), .voltage_in(volt), .power_in(pwr), .speed_cmd_out(cmd),
		.current_cap_out(cap), .brake_out(brk), .trip_out(trip),
		.power_limit_active_out(plim), .speed_pulse_output_out(pulse), .alarm_out(alarm));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk
	// Strobe held over one sampling edge, answer checked just after it
	task automatic rg(input fdps_row_t r);
		{sp, a, wr, rd, d} = {r.s, r.a, r.w, !r.w, r.d};
		tick(1);
		{wr, rd} = 2'b00;
		chk(16'(ack), 16'h0001);
		chk(16'(err), 16'(r.r));
		if (!r.w) chk(rdata, r.e);
		tick(1);
	endtask : rg
	task automatic final_report();
		$display("n_errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			final_report();
		end
	end
	initial begin
		rows = '{'{0, 8'h07, 0, 0, 16'h2260, 0}, '{0, 8'h24, 0, 0, 16'h0834, 0},
			'{0, 8'h1F, 0, 0, 0, 0}, '{0, 8'h2E, 0, 0, 0, 0}, '{0, 8'h32, 1, 16'h0032, 0, 0},
			'{0, 8'h32, 0, 0, 16'h0032, 0}, '{1, 8'h07, 1, 16'h1234, 0, 1},
			'{0, 8'h05, 0, 0, 0, 1}};
		tick(8);
		rst_in = 0;
		chk(cap, 16'h2260);
		for (k = 0; k < 8; k++) rg(rows[k]);
		run = 1;
		tick(100);
		chk(cmd, 16'h0000);
		rg('{1, 8'h02, 0, 0, mn, 0});
		tick(3800);
		chk(cmd, 16'h0000);
		tick(16200);
		chk(16'(cmd > 0 && cmd < mn), 16'h0001);
		rg('{1, 8'h02, 0, 0, mn, 0});
		tick(16500);
		chk(cmd, 16'h03E8);
		rg('{1, 8'h02, 0, 0, 16'h03E8, 0});
		rg('{1, 8'h03, 0, 0, 16'h03E8, 0});
		rg('{1, 8'h0D, 0, 0, 16'h00FA, 0});
		rg('{1, 8'h20, 0, 0, 16'h03E8, 0});
		rg('{1, 8'h0C, 0, 0, 16'h07D0, 0});
		tgt = 16'h0258;
		tick(100);
		chk(16'(cmd >= 16'h0361 && cmd <= 16'h0375), 16'h0001);
		tick(300);
		rg('{0, 8'h37, 1, 16'h01F4, 0, 0});
		tick(3);
		chk(16'(alarm), 16'h0000);
		rg('{0, 8'h2E, 1, 16'h0002, 0, 0});
		tick(3);
		chk(16'({alarm, pulse}), 16'h0003);
		rg('{0, 8'h37, 1, 16'h02BC, 0, 0});
		tick(3);
		chk(16'({alarm, pulse}), 16'h0000);
		rg('{0, 8'h24, 1, 16'h01F4, 0, 0});
		tick(200);
		chk(16'(plim && cmd < 16'h0258), 16'h0001);
		rg('{0, 8'h24, 1, 16'h0834, 0, 0});
		rg('{0, 8'h07, 1, 16'h0E10, 0, 0});
		chk(cap, 16'h0E10);
		itype = 8'h03;
		tick(600);
		chk(cmd, mspd);
		{itype, kp} = {8'h0C, 16'hFFFF};
		tick(400);
		chk(cmd, mx);
		rg('{1, 8'h02, 0, 0, mx, 0});
		rg('{0, 8'h1F, 1, 16'h0001, 0, 0});
		tick(1400);
		chk(cmd, mn);
		run = 0;
		tick(5);
		{rev, run} = {16'h0064, 1'b1};
		tick(50);
		chk(16'({brk, trip}), 16'h0002);
		rev = 16'h012C;
		tick(5);
		chk(16'(trip), 16'h0001);
		final_report();
	end
endmodule : fdps_supervisor_tb
